// ===== src/eab_bank.sv
// Energy accumulator bank with APB register access
//
// Summary of operation
// - Eight buckets: two fast, six slow.
// - Modes: power, current, constant, fundamental.
// - Power mode: A, B or A+B.
// - Power type: active, reactive or apparent.
// - Current mode: IA, IB or both.
// - Both currents: sum or IA minus IB.
// - Constant mode ignores channel selects.
// - Fundamental mode: channel 1, 2 or sum.
// - Op 0 adds positive inputs only.
// - Op 1 adds magnitude of negatives only.
// - Op 2 adds raw; op 3 absolute.
// - Fast buckets gated by their enable bits.
// - Fast rate 204.8 kHz, or 32768 Hz.
// - Each fast bucket can drive pulses.
// - Slow buckets gated by bit 15.
// - Slow default rate is 50 Hz.
// - Slow period from two control bits.
// - Rate 0: 20 ms, or 10 ms halves.
// - Rate 1: 40 ms, or 20 ms halves.
`timescale 1ns/100ps

module eab_bank
    import eab_pkg::*;
#(
    parameter int SLOW_BASE_DIV = SLOW_BASE_CYCLES   // Cycles per 10 ms base tick
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire eab_meter_in_t          meter_in,
    output logic [NUM_FAST-1:0]         energy_pulse_output
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Sign-extend a 32-bit datapath value to the sum width
    function automatic logic signed [SUM_W-1:0] eab_ext(input logic signed [31:0] v);
        eab_ext = SUM_W'(v);
    endfunction

    // Pick A only, B only or both; zero when neither is selected
    function automatic logic signed [SUM_W-1:0] eab_pair(
        input logic                    a_sel,
        input logic                    b_sel,
        input logic signed [SUM_W-1:0] a,
        input logic signed [SUM_W-1:0] b
    );
        eab_pair = (a_sel ? a : '0) + (b_sel ? b : '0);
    endfunction

    // Combined input of one bucket under its mode
    function automatic logic signed [SUM_W-1:0] eab_combine(
        input eab_bucket_cfg_t cfg,
        input eab_meter_in_t   mi,
        input logic [31:0]     konst
    );
        logic signed [SUM_W-1:0] pa;
        logic signed [SUM_W-1:0] pb;
        pa = eab_ext(mi.active_a);
        pb = eab_ext(mi.active_b);
        // Quantity type picks the power flavour; unused code falls back to active
        if (cfg.qty_type == QTY_REACTIVE) begin
            pa = eab_ext(mi.reactive_a);
            pb = eab_ext(mi.reactive_b);
        end else if (cfg.qty_type == QTY_APPARENT) begin
            pa = eab_ext(mi.apparent_a);
            pb = eab_ext(mi.apparent_b);
        end
        unique case (cfg.mode)
            EAB_MODE_POWER: begin
                eab_combine = eab_pair(cfg.a_sel, cfg.b_sel, pa, pb);
            end
            EAB_MODE_CURRENT: begin
                // Difference only when both channels are on and type bit 0 set
                if (cfg.a_sel && cfg.b_sel && cfg.qty_type[0]) begin
                    eab_combine = eab_ext(mi.rms_ia) - eab_ext(mi.rms_ib);
                end else begin
                    eab_combine = eab_pair(cfg.a_sel, cfg.b_sel,
                                           eab_ext(mi.rms_ia), eab_ext(mi.rms_ib));
                end
            end
            EAB_MODE_CONSTANT: begin
                eab_combine = eab_ext(konst);
            end
            EAB_MODE_FUND: begin
                eab_combine = eab_pair(cfg.a_sel, cfg.b_sel,
                                       eab_ext(mi.fund_1), eab_ext(mi.fund_2));
            end
        endcase
    endfunction

    // Sign handling; a zero result leaves the bucket untouched
    function automatic logic signed [SUM_W-1:0] eab_addend(
        input logic [1:0]              op,
        input logic signed [SUM_W-1:0] v
    );
        logic signed [SUM_W-1:0] mag;
        mag = v[SUM_W-1] ? -v : v;
        unique case (op)
            SIGN_POS: eab_addend = (v > 0) ? v : '0;
            SIGN_NEG: eab_addend = (v < 0) ? mag : '0;
            SIGN_RAW: eab_addend = v;
            SIGN_ABS: eab_addend = mag;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0]           ctrl0_reg;                         // metering_control_0
    logic [31:0]           ctrl1_reg;                         // metering_control_1
    logic [31:0]           const_reg;                         // Constant-mode value
    logic [31:0]           pulse_cfg_reg;                     // Pulse bit selects
    eab_bucket_cfg_t       cfg_reg     [NUM_BUCKETS];         // Per-bucket setup
    logic [ACC_W-1:0]      acc_reg     [NUM_BUCKETS];         // eight buckets
    logic [31:0]           prdata_reg;                        // Read data
    logic                  pready_reg;                        // Access-phase ready
    logic                  pslverr_reg;                       // Unmapped address
    logic [NUM_FAST-1:0]   pulse_reg;                         // Pulse outputs
    logic [FAST_CNT_W-1:0] fast_cnt_reg;                      // Fast divider
    logic                  fast_tick_reg;                     // Fast rate enable
    logic [SLOW_CNT_W-1:0] slow_cnt_reg;                      // 10 ms base divider
    logic [1:0]            step_cnt_reg;                      // Base ticks per period
    logic                  slow_tick_reg;                     // Slow rate enable

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire  [5:0]            word_idx   = paddr[7:2];           // Word index
    wire                   setup_ph   = psel && !penable && !pready_reg;
    wire                   wr_commit  = psel && penable && pready_reg && pwrite;
    wire                   hit_ctrl0  = (word_idx == IDX_CTRL0);
    wire                   hit_ctrl1  = (word_idx == IDX_CTRL1);
    wire                   hit_const  = (word_idx == IDX_CONST);
    wire                   hit_pulse  = (word_idx == IDX_PULSE);
    wire                   hit_cfg    = (word_idx[5:3] == IDX_CFG0[5:3]);
    wire                   hit_val    = (word_idx[5:3] == IDX_VAL0[5:3]);
    wire  [2:0]            sub_idx    = word_idx[2:0];        // Bucket number
    wire                   addr_ok    = hit_ctrl0 || hit_ctrl1 || hit_const || hit_pulse || hit_cfg || hit_val;

    // Read mux; config bytes sit low, upper bits read zero
    wire  [31:0]           rd_word    = hit_ctrl0 ? ctrl0_reg :
                                        hit_ctrl1 ? ctrl1_reg :
                                        hit_const ? const_reg :
                                        hit_pulse ? pulse_cfg_reg :
                                        hit_cfg   ? {{(32-CFG_W){1'b0}}, cfg_reg[sub_idx]} :
                                        hit_val   ? acc_reg[sub_idx] : 32'h0000_0000;

    // ------------------------------------------------------------
    // Rate selection
    // ------------------------------------------------------------
    wire                   fast_alt   = ctrl1_reg[BIT_FAST_CLK_SEL];
    wire  [FAST_CNT_W-1:0] fast_limit = fast_alt ? FAST_ALT_LIMIT : FAST_LIMIT;
    wire                   slow_half  = ctrl1_reg[BIT_SLOW_FAST_PER];
    wire                   data_rate  = ctrl0_reg[BIT_DATA_RATE];
    // Period in base ticks: 20/10 ms at rate 0, 40/20 ms at rate 1
    wire  [1:0]            step_limit = data_rate ? (slow_half ? STEP_20MS : STEP_40MS)
                                                  : (slow_half ? STEP_10MS : STEP_20MS);
    wire  [SLOW_CNT_W-1:0] slow_limit = SLOW_CNT_W'(SLOW_BASE_DIV - 1);
    wire                   base_tick  = (slow_cnt_reg >= slow_limit);
    wire                   slow_en    = ctrl1_reg[BIT_SLOW_EN];

    // ------------------------------------------------------------
    // Bucket datapath
    // ------------------------------------------------------------
    logic [NUM_BUCKETS-1:0] acc_en;                           // Bucket integrates now
    logic [ACC_W-1:0]       acc_sum  [NUM_BUCKETS];           // Value after this step
    logic [NUM_BUCKETS-1:0] clr_hit;                          // Software clear

    // Per-bucket gating and addend
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUCKETS; gi++) begin : g_bucket
            wire signed [SUM_W-1:0] comb_val = eab_combine(cfg_reg[gi], meter_in, const_reg);
            wire signed [SUM_W-1:0] add_val  = eab_addend(cfg_reg[gi].sign_op, comb_val);
            if (gi == 0) begin : g_f1
                assign acc_en[gi] = fast_tick_reg && ctrl1_reg[BIT_FAST1_EN];
            end else if (gi == 1) begin : g_f2
                assign acc_en[gi] = fast_tick_reg && ctrl1_reg[BIT_FAST2_EN];
            end else if (gi < FIRST_STOPPABLE) begin : g_s1
                assign acc_en[gi] = slow_tick_reg && slow_en;
            end else begin : g_s2
                // Upper three stop while the short period is chosen
                assign acc_en[gi] = slow_tick_reg && slow_en && !slow_half;
            end
            // Wrapping add; zero addend leaves the value as is
            assign acc_sum[gi] = acc_reg[gi] + add_val[ACC_W-1:0];
            assign clr_hit[gi] = wr_commit && hit_val && (sub_idx == 3'(gi));
        end
    endgenerate

    // Pulse bit select of each fast bucket
    wire  [PULSE_SEL_W-1:0] psel1 = pulse_cfg_reg[PULSE_SEL1_LSB +: PULSE_SEL_W];
    wire  [PULSE_SEL_W-1:0] psel2 = pulse_cfg_reg[PULSE_SEL2_LSB +: PULSE_SEL_W];
    wire  [NUM_FAST-1:0]    pulse_next = {acc_en[1] && (acc_sum[1][psel2] != acc_reg[1][psel2]),
                                          acc_en[0] && (acc_sum[0][psel1] != acc_reg[0][psel1])};

    // ------------------------------------------------------------
    // APB slave state
    // ------------------------------------------------------------

    // Ready rises in the first access cycle: one wait-free access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup_ph;
            // Capture answer in setup so it stands through access
            if (setup_ph) begin
                pslverr_reg <= !addr_ok;
                prdata_reg  <= (!pwrite && addr_ok) ? rd_word : 32'h0000_0000;
            end else if (pready_reg) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // Software-written control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg     <= CTRL_RESET;
            ctrl1_reg     <= CTRL_RESET;
            const_reg     <= CONST_RESET;
            pulse_cfg_reg <= CTRL_RESET;
        end else if (wr_commit) begin
            if (hit_ctrl0) begin
                ctrl0_reg <= pwdata;
            end
            if (hit_ctrl1) begin
                ctrl1_reg <= pwdata;
            end
            if (hit_const) begin
                const_reg <= pwdata;
            end
            if (hit_pulse) begin
                pulse_cfg_reg <= pwdata;
            end
        end
    end

    // Bucket configs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_BUCKETS; i++) begin
                cfg_reg[i] <= '0;
            end
        end else if (wr_commit && hit_cfg) begin
            cfg_reg[sub_idx] <= eab_bucket_cfg_t'(pwdata[CFG_W-1:0]);
        end
    end

    // ------------------------------------------------------------
    // Rate dividers
    // ------------------------------------------------------------

    // Fast tick; restart on rate change is not needed since limit is compared with >=
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cnt_reg  <= '0;
            fast_tick_reg <= 1'b0;
        end else begin
            fast_tick_reg <= (fast_cnt_reg >= fast_limit);
            fast_cnt_reg  <= (fast_cnt_reg >= fast_limit) ? '0 : fast_cnt_reg + 1'b1;
        end
    end

    // Slow tick: 10 ms base, then 1, 2 or 4 base ticks per period (20 ms by default)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt_reg  <= '0;
            step_cnt_reg  <= '0;
            slow_tick_reg <= 1'b0;
        end else begin
            slow_cnt_reg  <= base_tick ? '0 : slow_cnt_reg + 1'b1;
            slow_tick_reg <= base_tick && (step_cnt_reg >= step_limit);
            if (base_tick) begin
                step_cnt_reg <= (step_cnt_reg >= step_limit) ? 2'h0 : step_cnt_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulators and pulses
    // ------------------------------------------------------------

    // Clear by write; an integration in the same cycle is kept, not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_BUCKETS; i++) begin
                acc_reg[i] <= '0;
            end
            pulse_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_BUCKETS; i++) begin
                if (clr_hit[i]) begin
                    acc_reg[i] <= acc_en[i] ? acc_sum[i] - acc_reg[i] : '0;
                end else if (acc_en[i]) begin
                    acc_reg[i] <= acc_sum[i];
                end
                // Disabled bucket keeps its value
            end
            pulse_reg <= pulse_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign energy_pulse_output = pulse_reg;

endmodule // eab_bank

// ===== src/eab_pkg.sv
// Package for the energy accumulator bank: map, fields, rates and carriers
package eab_pkg;

    // ------------------------------------------------------------
    // Clock and rates
    // ------------------------------------------------------------
    localparam int CLK_HZ              = 125_000_000;  // pclk rate
    localparam int FAST_RATE_DHZ       = 2_048_000;    // 204.8 kHz, in tenths of Hz
    localparam int FAST_ALT_RATE_HZ    = 32_768;       // Alternate fast rate
    localparam int SLOW_BASE_MS        = 10;           // Shortest slow period
    localparam int FAST_DIV            = (CLK_HZ * 10) / FAST_RATE_DHZ;
    localparam int FAST_ALT_DIV        = CLK_HZ / FAST_ALT_RATE_HZ;
    localparam int SLOW_BASE_CYCLES    = (CLK_HZ / 1000) * SLOW_BASE_MS;
    localparam int FAST_CNT_W          = 12;
    localparam int SLOW_CNT_W          = 24;
    localparam logic [FAST_CNT_W-1:0] FAST_LIMIT     = FAST_CNT_W'(FAST_DIV - 1);
    localparam logic [FAST_CNT_W-1:0] FAST_ALT_LIMIT = FAST_CNT_W'(FAST_ALT_DIV - 1);
    // Base ticks per slow period, minus one: 10, 20 and 40 ms
    localparam logic [1:0] STEP_10MS   = 2'h0;
    localparam logic [1:0] STEP_20MS   = 2'h1;
    localparam logic [1:0] STEP_40MS   = 2'h3;

    // ------------------------------------------------------------
    // Bank shape
    // ------------------------------------------------------------
    localparam int NUM_BUCKETS         = 8;
    localparam int NUM_FAST            = 2;
    localparam int FIRST_STOPPABLE     = 5;            // Buckets 6..8 (zero based 5..7)
    localparam int ACC_W               = 32;
    localparam int SUM_W               = 34;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL0   = 6'h02;        // metering_control_0
    localparam logic [5:0] IDX_CTRL1   = 6'h03;        // metering_control_1
    localparam logic [5:0] IDX_CONST   = 6'h04;        // Constant-mode input value
    localparam logic [5:0] IDX_PULSE   = 6'h05;        // Pulse bit selects
    localparam logic [5:0] IDX_CFG0    = 6'h08;        // Bucket configs 0x08..0x0F
    localparam logic [5:0] IDX_VAL0    = 6'h10;        // Bucket values 0x10..0x17
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CONST_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DATA_RATE       = 31;           // In control 0
    localparam int BIT_FAST1_EN        = 6;            // In control 1
    localparam int BIT_FAST2_EN        = 7;
    localparam int BIT_SLOW_EN         = 15;
    localparam int BIT_SLOW_FAST_PER   = 22;
    localparam int BIT_FAST_CLK_SEL    = 23;
    localparam int PULSE_SEL_W         = 5;
    localparam int PULSE_SEL1_LSB      = 0;
    localparam int PULSE_SEL2_LSB      = 8;

    // ------------------------------------------------------------
    // Modes and encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EAB_MODE_POWER    = 2'h0,
        EAB_MODE_CURRENT  = 2'h1,
        EAB_MODE_CONSTANT = 2'h2,
        EAB_MODE_FUND     = 2'h3
    } eab_mode_t;

    localparam logic [1:0] QTY_ACTIVE   = 2'h0;
    localparam logic [1:0] QTY_REACTIVE = 2'h1;
    localparam logic [1:0] QTY_APPARENT = 2'h2;
    localparam logic [1:0] SIGN_POS     = 2'h0;
    localparam logic [1:0] SIGN_NEG     = 2'h1;
    localparam logic [1:0] SIGN_RAW     = 2'h2;
    localparam logic [1:0] SIGN_ABS     = 2'h3;

    // Per-bucket configuration word (low byte of its register)
    typedef struct packed {
        logic [1:0] sign_op;
        logic [1:0] qty_type;
        logic       b_sel;
        logic       a_sel;
        eab_mode_t  mode;
    } eab_bucket_cfg_t;

    localparam int CFG_W = $bits(eab_bucket_cfg_t);

    // Values delivered by the metering datapath, all signed
    typedef struct packed {
        logic signed [31:0] active_a;
        logic signed [31:0] active_b;
        logic signed [31:0] reactive_a;
        logic signed [31:0] reactive_b;
        logic signed [31:0] apparent_a;
        logic signed [31:0] apparent_b;
        logic signed [31:0] rms_ia;
        logic signed [31:0] rms_ib;
        logic signed [31:0] fund_1;
        logic signed [31:0] fund_2;
    } eab_meter_in_t;

endpackage : eab_pkg

// ===== dv/eab_meter_model.sv
// Metering datapath stand-in that feeds fixed signed samples
`timescale 1ns/100ps
module eab_meter_model
    import eab_pkg::*;
(
    input  wire logic     pclk,
    output eab_meter_in_t meter_in
);
    // Mixed signs, so that every sign operation has work to do
    assign meter_in = '{32'h5, 32'hFFFFFFF8, 32'h7, 32'h2, 32'hB, 32'hD, 32'h14, 32'h6, 32'hFFFFFFFC, 32'h9};
endmodule // eab_meter_model

// ===== dv/eab_bank_asserts.sv
// Port-level checker for the energy accumulator bank
`timescale 1ns/100ps
module eab_bank_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  energy_pulse_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [5:0] idx    = paddr[7:2];                              // Word index
    wire       map_ok = (idx >= 6'h02 && idx <= 6'h05) || (idx >= 6'h08 && idx <= 6'h17);
    wire       setup  = psel && !penable;                        // Setup cycle
    property p_rdy_ack;   setup |=> pready;                                     endproperty
    property p_rdy_only;  pready |-> psel && penable;                           endproperty
    property p_rdy_one;   pready |=> !pready;                                   endproperty
    property p_err_map;   setup && !map_ok |=> pslverr;                         endproperty
    property p_ok_map;    setup && map_ok |=> !pslverr;                         endproperty
    property p_err_zero;  pslverr |-> pready && prdata == 32'h0;                endproperty
    property p_wr_zero;   pready && pwrite |-> prdata == 32'h0;                 endproperty
    property p_pulse_one; energy_pulse_output[0] |=> !energy_pulse_output[0];   endproperty
    a_rdy_ack:   assert property (p_rdy_ack)   else $error("no ready after setup");
    a_rdy_only:  assert property (p_rdy_only)  else $error("ready outside access");
    a_rdy_one:   assert property (p_rdy_one)   else $error("ready held too long");
    a_err_map:   assert property (p_err_map)   else $error("unmapped not refused");
    a_ok_map:    assert property (p_ok_map)    else $error("mapped refused");
    a_err_zero:  assert property (p_err_zero)  else $error("error data not zero");
    a_wr_zero:   assert property (p_wr_zero)   else $error("write data not zero");
    a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one cycle");
    c_err:   cover property (pslverr);
    c_pulse: cover property (energy_pulse_output[0]);
    c_write: cover property (pready && pwrite);
endmodule // eab_bank_asserts

bind eab_bank eab_bank_asserts i_eab_bank_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .energy_pulse_output(energy_pulse_output));

// ===== dv/eab_bank_bench.sv
// Self-checking bench for the energy accumulator bank
`timescale 1ns/100ps
module eab_bank_bench
    import eab_pkg::*;
;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0, prdata, rd;
    logic          pready, pslverr, er;
    logic [1:0]    pulse;
    eab_meter_in_t meter_in;
    int            error_cnt = 0, total_checks = 0, pulse_cnt = 0;
    // Fast cases: config byte and single-tick addend
    logic [7:0]  cfg [15] = '{8'h84, 8'h88, 8'h0C, 8'h4C, 8'hCC, 8'h1C, 8'hAC, 8'h85, 8'h89, 8'h8D, 8'h9D,
                              8'h82, 8'h87, 8'h4B, 8'h8F};
    logic [31:0] exv [15] = '{32'h5, 32'hFFFFFFF8, 32'h0, 32'h3, 32'h3, 32'h9, 32'h18, 32'h14, 32'h6, 32'h1A,
                              32'hE, 32'h64, 32'hFFFFFFFC, 32'h0, 32'h5};
    // Slow cases: control words and period in pclk cycles (base tick 50)
    logic [31:0] c0 [4] = '{32'h0, 32'h0, 32'h80000000, 32'h80000000};
    logic [31:0] c1 [4] = '{32'h408000, 32'h8000, 32'h8000, 32'h408000};
    int          per [4] = '{50, 100, 200, 100};
    always #4 pclk = ~pclk;
    eab_meter_model i_eab_meter_model (.pclk(pclk), .meter_in(meter_in));
    eab_bank #(.SLOW_BASE_DIV(50)) i_eab_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meter_in(meter_in), .energy_pulse_output(pulse));
    // Count pulses mid-cycle, clear of the launching edge
    always @(negedge pclk) if (pulse[0] === 1'b1) pulse_cnt++;
    // One APB transfer; answer taken in the cycle it stands
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) error_cnt++;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] e2, input logic [31:0] g);
        total_checks++;
        if (g !== e && g !== e2) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi, input logic [31:0] g);
        total_checks++;
        if ($isunknown(g) || int'(g) < lo || int'(g) > hi) begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %h", s, lo, hi, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog, well past the expected 26k cycles
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        chk("control0", 32'h0, 32'h0, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("control1", 32'h0, 32'h0, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, 32'h1, {31'h0, er});
        apb(1'b1, 8'h10, 32'h64);
        apb(1'b1, 8'h14, 32'h2);
        $display("test registers done");
        foreach (cfg[i]) begin
            apb(1'b1, 8'h20, {24'h0, cfg[i]});
            apb(1'b1, 8'h24, {24'h0, cfg[i]});
            apb(1'b1, 8'h40, 32'h0);
            apb(1'b1, 8'h44, 32'h0);
            apb(1'b1, 8'h0C, 32'h40);
            repeat (1000) @(posedge pclk);
            apb(1'b1, 8'h0C, 32'h0);
            apb(1'b0, 8'h40, 32'h0);
            chk("bucket1", exv[i], exv[i] * 2, rd);
            apb(1'b0, 8'h44, 32'h0);
            chk("bucket2", 32'h0, 32'h0, rd);
        end
        $display("test fast modes done");
        apb(1'b1, 8'h28, 32'h82);
        apb(1'b1, 8'h34, 32'h82);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h48, 32'h0);
            apb(1'b1, 8'h54, 32'h0);
            apb(1'b1, 8'h08, c0[k]);
            apb(1'b1, 8'h0C, c1[k]);
            repeat (600) @(posedge pclk);
            apb(1'b1, 8'h0C, 32'h0);
            apb(1'b0, 8'h48, 32'h0);
            rng("bucket3", (600 / per[k] - 1) * 100, (600 / per[k] + 1) * 100, rd);
            apb(1'b0, 8'h54, 32'h0);
            rng("bucket6", c1[k][22] ? 0 : (600 / per[k] - 1) * 100, c1[k][22] ? 0 : (600 / per[k] + 1) * 100, rd);
        end
        $display("test slow periods done");
        apb(1'b1, 8'h20, 32'h82);
        apb(1'b1, 8'h40, 32'h0);
        pulse_cnt = 0;
        apb(1'b1, 8'h0C, 32'h800040);
        repeat (8000) @(posedge pclk);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        rng("bucket1 alt rate", 100, 300, rd);
        rng("pulses", 1, 3, pulse_cnt);
        $display("test clock select done");
        stop_test();
    end
endmodule // eab_bank_bench
